//--- dmah_top.sv
// Contract
// - four-slot mode: the four enables drive one slot each
// - more slots: the four pins carry an encoded slot number
// - command bit 6 clear means requests active high, set active low
// - request assertion is asynchronous and gets synchronised first
// - acknowledge asserted on grant, polarity set by command setting
// - non-compatible timing: competitor plus 4 us negates acknowledge
// - preempted channel resumes its transfer on its next win
// - input mode: slave may end transfer, pin sampled on every type
// - sampled end of process tristates address and ends the transfer
// - output mode pulses the pin when byte count reaches last value
// - terminal count asserted after the new address is output
// - held until address enable drops, earlier under autoinit
// - idle or after reset the pin is output mode; reset also negates it
`default_nettype none
module dmah_top
  import dmah_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // configuration
  input  wire logic [7:0]           dmaCommand,
  input  wire logic                 compatTiming,
  input  wire logic                 processEndInputMode,
  input  wire logic                 fourSlotMode,
  // request pins and arbiter view
  input  wire logic [NUM_CHAN-1:0]  dmaReqPin,
  output var  logic [NUM_CHAN-1:0]  reqActive,
  // grant from arbiter, same clock
  input  wire logic                 grantValid,
  input  wire logic [CHAN_W-1:0]    grantChan,
  input  wire logic                 otherBusReq,
  // transfer progress from the engine
  input  wire logic                 newAddrOut,
  input  wire logic                 byteCountLast,
  input  wire logic                 xferDone,
  input  wire logic                 autoInit,
  input  wire logic                 addrEnable,
  // acknowledge pins
  output var  logic [NUM_CHAN-1:0]  dmaAckPin,
  // transfer status
  output var  logic                 xferActive,
  output var  logic [CHAN_W-1:0]    activeChan,
  output var  logic                 xferTerminated,
  output var  logic                 xferPreempted,
  output var  logic [NUM_CHAN-1:0]  resumePending,
  output var  logic                 addrOe,
  // end of process pin
  input  wire logic                 endOfProcessIn,
  output var  logic                 endOfProcessOut,
  output var  logic                 endOfProcessOe,
  // slot address enables
  input  wire logic [SLOT_W-1:0]    slotSel,
  input  wire logic                 slotAenActive,
  output var  logic [NUM_SLOT_PINS-1:0] encodedSlotEnable
);
  dmah_tmr_if tmr ();

  logic [NUM_CHAN-1:0]      reqSync;
  logic                     endSync;
  logic [NUM_CHAN-1:0]      reqActive_q;
  logic [NUM_CHAN-1:0]      reqActive_d;
  dmah_ack_state_t          state_q;
  dmah_ack_state_t          state_d;
  logic [CHAN_W-1:0]        chan_q;
  logic [CHAN_W-1:0]        chan_d;
  logic [NUM_CHAN-1:0]      ack_q;
  logic [NUM_CHAN-1:0]      ack_d;
  logic                     term_q;
  logic                     term_d;
  logic                     pre_q;
  logic                     pre_d;
  logic [NUM_CHAN-1:0]      resume_q;
  logic [NUM_CHAN-1:0]      resume_d;
  logic                     addrOe_q;
  logic                     addrOe_d;
  logic                     tc_q;
  logic                     tc_d;
  logic                     pinOe_q;
  logic                     pinOe_d;
  logic                     pinOut_q;
  logic                     pinOut_d;
  logic [NUM_SLOT_PINS-1:0] slot_q;
  logic [NUM_SLOT_PINS-1:0] slot_d;
  logic                     busy;
  logic                     inputMode;
  logic                     endSeen;
  logic                     preemptNow;

  // one-hot channel select
  function automatic logic [NUM_CHAN-1:0] chanHot(input logic [CHAN_W-1:0] c);
    chanHot = 8'h01 << c;
  endfunction

  dmah_sync #(
    .WIDTH   (NUM_CHAN)
  ) u_reqSync (
    .clk     (clk),
    .rst_b   (rst_b),
    .asyncIn (dmaReqPin),
    .syncOut (reqSync)
  );

  // end of process input sampling
  dmah_sync #(
    .WIDTH   (1)
  ) u_endSync (
    .clk     (clk),
    .rst_b   (rst_b),
    .asyncIn (endOfProcessIn),
    .syncOut (endSync)
  );

  // preemption interval counter
  dmah_preempt_tmr u_tmr (
    .clk   (clk),
    .rst_b (rst_b),
    .tmr   (tmr.timer)
  );

  // decode of current activity
  assign busy       = (state_q == ACK_BUSY);
  assign inputMode  = processEndInputMode && busy;
  // pin watched during every transfer type
  assign endSeen    = inputMode && (endSync == END_ASSERTED);
  assign preemptNow = busy && tmr.expired;
  // counter runs with competitor in fast timing
  assign tmr.run    = busy && !compatTiming && otherBusReq;

  always_comb
  begin
    reqActive_d = '0;
    // command bit 6 picks request level
    if (dmaCommand[CMD_REQ_POL_BIT])
    begin
      reqActive_d = ~reqSync & CHAN_USED;
    end
    else
    begin
      reqActive_d = reqSync & CHAN_USED;
    end
  end

  // acknowledge state machine
  always_comb
  begin
    state_d  = state_q;
    chan_d   = chan_q;
    term_d   = 1'b0;
    pre_d    = 1'b0;
    resume_d = resume_q;
    addrOe_d = addrOe_q;
    unique case (state_q)
      ACK_IDLE:
      begin
        addrOe_d = 1'b0;
        if (grantValid && CHAN_USED[grantChan])
        begin
          state_d  = ACK_BUSY;
          chan_d   = grantChan;
          addrOe_d = 1'b1;
        end
      end
      ACK_BUSY:
      begin
        if (endSeen)
        begin
          state_d  = ACK_IDLE;
          addrOe_d = 1'b0;
          term_d   = 1'b1;
          resume_d = resume_q & ~chanHot(chan_q);
        end
        else if (preemptNow)
        begin
          state_d  = ACK_IDLE;
          addrOe_d = 1'b0;
          pre_d    = 1'b1;
          resume_d = resume_q | chanHot(chan_q);
        end
        else if (xferDone)
        begin
          state_d  = ACK_IDLE;
          addrOe_d = 1'b0;
          resume_d = resume_q & ~chanHot(chan_q);
        end
      end
    endcase
    if (!rst_b)
    begin
      state_d  = ACK_IDLE;
      chan_d   = '0;
      term_d   = 1'b0;
      pre_d    = 1'b0;
      resume_d = '0;
      addrOe_d = 1'b0;
    end
  end

  always_comb
  begin
    ack_d = '0;
    if (state_d == ACK_BUSY)
    begin
      ack_d = chanHot(chan_d);
    end
    if (!dmaCommand[CMD_ACK_POL_BIT])
    begin
      ack_d = ~ack_d;
    end
    if (!rst_b)
    begin
      ack_d = dmaCommand[CMD_ACK_POL_BIT] ? 8'h00 : 8'hff;
    end
  end

  // terminal count and pin direction
  always_comb
  begin
    tc_d = tc_q;
    if (busy && !processEndInputMode && newAddrOut && byteCountLast)
    begin
      tc_d = 1'b1;
    end
    // drop with enable, or earlier in autoinit
    else if (!addrEnable || (autoInit && xferDone))
    begin
      tc_d = 1'b0;
    end
    if (processEndInputMode)
    begin
      tc_d = 1'b0;
    end
    pinOe_d  = !(processEndInputMode && (state_d == ACK_BUSY));
    pinOut_d = pinOe_d ? (tc_d ? END_ASSERTED : ~END_ASSERTED)
                       : ~END_ASSERTED;
    if (!rst_b)
    begin
      tc_d     = 1'b0;
      pinOe_d  = 1'b1;
      pinOut_d = ~END_ASSERTED;
    end
  end

  // slot address enable pins
  always_comb
  begin
    slot_d = '0;
    if (slotAenActive)
    begin
      if (fourSlotMode)
      begin
        slot_d = 4'h1 << slotSel[1:0];
      end
      else
      begin
        slot_d = {1'b0, slotSel} + 4'h1;
      end
    end
    if (!rst_b)
    begin
      slot_d = '0;
    end
  end

  // register stage for all state and outputs
  always_ff @(posedge clk)
  begin
    reqActive_q <= rst_b ? reqActive_d : '0;
    state_q     <= state_d;
    chan_q      <= chan_d;
    ack_q       <= ack_d;
    term_q      <= term_d;
    pre_q       <= pre_d;
    resume_q    <= resume_d;
    addrOe_q    <= addrOe_d;
    tc_q        <= tc_d;
    pinOe_q     <= pinOe_d;
    pinOut_q    <= pinOut_d;
    slot_q      <= slot_d;
  end

  // outputs straight from flops
  assign reqActive         = reqActive_q;
  assign dmaAckPin         = ack_q;
  assign xferActive        = busy;
  assign activeChan        = chan_q;
  assign xferTerminated    = term_q;
  assign xferPreempted     = pre_q;
  assign resumePending     = resume_q;
  assign addrOe            = addrOe_q;
  assign endOfProcessOut   = pinOut_q;
  assign endOfProcessOe    = pinOe_q;
  assign encodedSlotEnable = slot_q;
endmodule // dmah_top
`default_nettype wire

//--- dmah_pkg.sv
`default_nettype none
package dmah_pkg;
  // channel and slot geometry
  localparam int          NUM_CHAN      = 8;
  localparam int          CHAN_W        = 3;
  localparam int          NUM_SLOT_PINS = 4;
  localparam int          SLOT_W        = 3;
  localparam int          SYNC_STAGES   = 2;
  // channel 4 is the cascade position and never acknowledges
  localparam logic [7:0]  CHAN_USED     = 8'hef;
  // command setting bit positions
  localparam int          CMD_REQ_POL_BIT = 6;
  localparam int          CMD_ACK_POL_BIT = 7;
  localparam logic [7:0]  CMD_RESET       = 8'h00;
  // preemption interval
  localparam int          CLK_MHZ        = 100;
  localparam int          PREEMPT_US     = 4;
  localparam int          PREEMPT_CYC    = PREEMPT_US * CLK_MHZ;
  localparam int          TMR_W          = 9;
  localparam logic [8:0]  PREEMPT_LAST   = 9'(PREEMPT_CYC - 1);
  // terminal count pin is active high on the bus
  localparam logic        END_ASSERTED   = 1'b1;

  typedef enum logic [0:0] {
    ACK_IDLE,
    ACK_BUSY
  } dmah_ack_state_t;
endpackage : dmah_pkg
`default_nettype wire

//--- dmah_tmr_if.sv
`default_nettype none
interface dmah_tmr_if;
  logic run;
  logic expired;
  modport owner (output run, input expired);
  modport timer (input run, output expired);
endinterface : dmah_tmr_if
`default_nettype wire

//--- dmah_sync.sv
`default_nettype none
module dmah_sync
  import dmah_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // two flop chain, first stage feeds only the second
  always_comb
  begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;
endmodule // dmah_sync
`default_nettype wire

//--- dmah_preempt_tmr.sv
`default_nettype none
module dmah_preempt_tmr
  import dmah_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // run and expiry
  dmah_tmr_if.timer tmr
);
  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;
  logic             exp_q;
  logic             exp_d;

  // counts while run holds, clears as soon as it drops
  always_comb
  begin
    cnt_d = '0;
    exp_d = 1'b0;
    if (tmr.run)
    begin
      if (cnt_q == PREEMPT_LAST)
      begin
        cnt_d = cnt_q;
        exp_d = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q + 9'h001;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign tmr.expired = exp_q;
endmodule // dmah_preempt_tmr
`default_nettype wire

//--- dmah_top_assertions.sv
`default_nettype none
module dmah_chk
  import dmah_pkg::*;
(
  // clock and reset
  input wire logic                clk,
  input wire logic                rst_b,
  // configuration and requests
  input wire logic [7:0]          dmaCommand,
  input wire logic                compatTiming,
  input wire logic                processEndInputMode,
  input wire logic                fourSlotMode,
  input wire logic [NUM_CHAN-1:0] dmaReqPin,
  input wire logic [NUM_CHAN-1:0] reqActive,
  // grant and progress
  input wire logic                grantValid,
  input wire logic [CHAN_W-1:0]   grantChan,
  input wire logic                otherBusReq,
  input wire logic                newAddrOut,
  input wire logic                byteCountLast,
  input wire logic                xferDone,
  input wire logic                autoInit,
  input wire logic                addrEnable,
  // outputs watched
  input wire logic [NUM_CHAN-1:0] dmaAckPin,
  input wire logic                xferActive,
  input wire logic [CHAN_W-1:0]   activeChan,
  input wire logic                xferPreempted,
  input wire logic                addrOe,
  input wire logic                endOfProcessIn,
  input wire logic                endOfProcessOut,
  input wire logic                endOfProcessOe,
  input wire logic [SLOT_W-1:0]   slotSel,
  input wire logic                slotAenActive,
  input wire logic [3:0]          encodedSlotEnable
);
  logic [9:0] runCnt_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // consecutive cycles of competing request in a fast-mode transfer
  always_ff @(posedge clk)
    if (!rst_b || !(xferActive && !compatTiming && otherBusReq))
      runCnt_q <= 10'h000;
    else
      runCnt_q <= runCnt_q + 10'h001;

  ack_reset_a: assert property ($rose(rst_b) |->
    dmaAckPin == {8{~dmaCommand[7]}}) else $error("ack active at reset");
  pin_idle_a: assert property ($rose(rst_b) |->
    endOfProcessOe && !endOfProcessOut) else $error("end pin not idle");
  req_sync_a: assert property ($past(rst_b, 3) && $past(rst_b, 2) &&
    $past(rst_b) |-> reqActive == (($past(dmaReqPin, 3) ^
    {8{$past(dmaCommand[6])}}) & CHAN_USED)) else $error("request path");
  grant_ack_a: assert property (!xferActive && grantValid &&
    grantChan != 3'h4 |=> xferActive && addrOe &&
    activeChan == $past(grantChan)) else $error("grant not taken");
  ack_level_a: assert property (xferActive |-> dmaAckPin ==
    (dmaCommand[7] ? 8'h01 << activeChan : ~(8'h01 << activeChan)))
    else $error("ack level wrong");
  preempt_time_a: assert property (xferPreempted |->
    runCnt_q >= 10'h18e && runCnt_q <= 10'h194) else $error("preempt time");
  end_term_a: assert property (xferActive && processEndInputMode &&
    endOfProcessIn |-> ##[1:4] !xferActive && !addrOe)
    else $error("end of process not honoured");
  tc_set_a: assert property (xferActive && !processEndInputMode &&
    newAddrOut && byteCountLast |=> endOfProcessOut && endOfProcessOe)
    else $error("tc not raised");
  tc_hold_a: assert property (endOfProcessOut && addrEnable &&
    !(autoInit && xferDone) |=> endOfProcessOut) else $error("tc dropped");
  slot_enable_a: assert property (rst_b |=> encodedSlotEnable ==
    (!$past(slotAenActive) ? 4'h0 : $past(fourSlotMode) ?
    4'h1 << $past(slotSel[1:0]) : 4'($past(slotSel)) + 4'h1))
    else $error("slot enable wrong");

  // main scenarios reached
  cover property (xferPreempted);
  cover property (endOfProcessOut && xferActive);
  cover property (grantValid && grantChan == 3'h4);
endmodule // dmah_chk
`default_nettype wire

//--- dmah_slave.sv
`default_nettype none
module dmah_slave
  import dmah_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // bench control
  input  wire logic [NUM_CHAN-1:0] start,
  input  wire logic                stopXfer,
  input  wire logic                reqLow,
  input  wire logic                ackHigh,
  // pins
  input  wire logic [NUM_CHAN-1:0] ackPin,
  output var  logic [NUM_CHAN-1:0] reqPin,
  output var  logic                pinDrive,
  output var  logic                masterDrive
);
  logic [NUM_CHAN-1:0] reqOn_q;
  logic [NUM_CHAN-1:0] seen_q;
  logic [NUM_CHAN-1:0] ackNow;

  assign ackNow = ackHigh ? ackPin : ~ackPin;
  // hold request until ack negated, negated after reset
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      reqOn_q <= '0;
      seen_q <= '0;
    end
    else
    begin
      reqOn_q <= (reqOn_q | start) & ~(seen_q & ~ackNow);
      seen_q <= (seen_q | (ackNow & reqOn_q)) & ackNow;
    end
  end
  assign reqPin = reqLow ? ~reqOn_q : reqOn_q;
  // end the transfer only while selected
  assign pinDrive = stopXfer && |(ackNow & reqOn_q);
  // master 16-bit drive only inside its acknowledge
  assign masterDrive = |(ackNow & reqOn_q);
endmodule // dmah_slave
`default_nettype wire

//--- tb_dma_handshake_eop_aen.sv
`default_nettype none
module tb_dma_handshake_eop_aen;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, compatTiming = 1'b1;
  logic processEndInputMode = 1'b0, fourSlotMode = 1'b0, grantValid = 1'b0;
  logic otherBusReq = 1'b0, newAddrOut = 1'b0, byteCountLast = 1'b0;
  logic xferDone = 1'b0, autoInit = 1'b0, addrEnable = 1'b0;
  logic slotAenActive = 1'b0, stopXfer = 1'b0, pinDrive, endOfProcessIn;
  logic masterDrive;
  logic xferActive, xferTerminated, xferPreempted, addrOe;
  logic endOfProcessOut, endOfProcessOe;
  logic [7:0] dmaCommand = 8'h00, start = 8'h00, dmaReqPin, reqActive;
  logic [7:0] dmaAckPin, resumePending;
  logic [2:0] grantChan = 3'h0, slotSel = 3'h0, activeChan;
  logic [3:0] encodedSlotEnable;
  logic [8:0] rows [7] = '{9'h181, 9'h1b8, 9'h1e4, 9'h101, 9'h178, 9'h0a0,
    9'h145};
  int bad_count = 0;
  int checks_done = 0;
  int i;

  dmah_top dmah_top_inst (.*);
  dmah_slave dmah_slave_inst (.clk, .rst_b, .start, .stopXfer,
    .reqLow(dmaCommand[6]), .ackHigh(dmaCommand[7]), .ackPin(dmaAckPin),
    .reqPin(dmaReqPin), .pinDrive, .masterDrive);
  // pin wire: design drives when enabled, else slave, pulled low idle
  assign endOfProcessIn = endOfProcessOe ? endOfProcessOut : pinDrive;
  always #5 clk = ~clk;

  task tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(logic [15:0] got, logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    if (bad_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task bound(int k, int n);
    if (k >= n)
    begin
      $display("Error t=%0t wait ran out", $time);
      bad_count++;
      wrap_up();
    end
  endtask
  task grant(logic [2:0] c);
    grantChan = c;
    grantValid = 1'b1;
    tick(1);
    grantValid = 1'b0;
  endtask
  task end_xfer;
    xferDone = 1'b1;
    tick(1);
    xferDone = 1'b0;
  endtask

  // main sequence
  initial
  begin
    tick(8);
    chk(dmaAckPin, 8'hff);
    chk({endOfProcessOe, endOfProcessOut}, 2'b10);
    rst_b = 1'b1;
    for (int k = 0; k < 7; k++)
    begin
      {slotAenActive, fourSlotMode, slotSel} = rows[k][8:4];
      tick(1);
      chk(encodedSlotEnable, rows[k][3:0]);
    end
    start = 8'h04;
    tick(1);
    start = 8'h00;
    tick(2);
    chk(reqActive, 8'h00);
    tick(1);
    chk(reqActive, 8'h04);
    addrEnable = 1'b1;
    grant(3'h2);
    chk({dmaAckPin, addrOe}, {8'hfb, 1'b1});
    newAddrOut = 1'b1;
    byteCountLast = 1'b1;
    tick(1);
    newAddrOut = 1'b0;
    chk(endOfProcessOut, 1'b1);
    end_xfer();
    chk({dmaAckPin, endOfProcessOut}, {8'hff, 1'b1});
    addrEnable = 1'b0;
    tick(1);
    chk(endOfProcessOut, 1'b0);
    tick(4);
    chk(reqActive, 8'h00);
    dmaCommand = 8'hc0;
    start = 8'h20;
    tick(1);
    start = 8'h00;
    tick(3);
    chk({reqActive, dmaAckPin}, {8'h20, 8'h00});
    grant(3'h5);
    chk(dmaAckPin, 8'h20);
    chk(masterDrive, 1'b1);
    processEndInputMode = 1'b1;
    stopXfer = 1'b1;
    for (i = 0; i < 8 && !xferTerminated; i++)
      tick(1);
    bound(i, 8);
    chk({xferActive, addrOe, dmaAckPin}, 10'h000);
    chk(masterDrive, 1'b0);
    stopXfer = 1'b0;
    processEndInputMode = 1'b0;
    grant(3'h4);
    chk(xferActive, 1'b0);
    compatTiming = 1'b0;
    tick(1);
    grant(3'h6);
    otherBusReq = 1'b1;
    for (i = 0; i < 450 && !xferPreempted; i++)
      tick(1);
    bound(i, 450);
    chk(i >= 395 && i <= 405, 1'b1);
    chk({resumePending, dmaAckPin}, {8'h40, 8'h00});
    otherBusReq = 1'b0;
    grant(3'h6);
    end_xfer();
    chk(resumePending, 8'h00);
    compatTiming = 1'b1;
    grant(3'h1);
    otherBusReq = 1'b1;
    tick(450);
    chk(xferActive, 1'b1);
    grant(3'h3);
    chk({activeChan, dmaAckPin}, {3'h1, 8'h02});
    addrEnable = 1'b1;
    autoInit = 1'b1;
    newAddrOut = 1'b1;
    tick(1);
    newAddrOut = 1'b0;
    chk(endOfProcessOut, 1'b1);
    end_xfer();
    chk({endOfProcessOut, xferActive}, 2'b00);
    autoInit = 1'b0;
    addrEnable = 1'b0;
    grant(3'h3);
    rst_b = 1'b0;
    tick(1);
    chk({dmaAckPin, xferActive, addrOe}, 10'h000);
    chk({endOfProcessOe, endOfProcessOut}, 2'b10);
    rst_b = 1'b1;
    tick(2);
    chk(dmaAckPin, 8'h00);
    wrap_up();
  end
endmodule // tb_dma_handshake_eop_aen

bind dmah_top dmah_chk dmah_chk_inst (.*);
`default_nettype wire
